// *** core/pfm_pkg.sv ***
package pfm_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_FSEL_LO  = 8'h00;
    localparam logic [7:0] OFS_FSEL_HI  = 8'h04;
    localparam logic [7:0] OFS_DATA     = 8'h08;
    localparam logic [7:0] OFS_DIR      = 8'h0c;
    localparam logic [7:0] OFS_BITOP    = 8'h10;
    localparam logic [7:0] OFS_PIN      = 8'h14;
    localparam logic [7:0] OFS_WAKE_EN  = 8'h18;
    localparam logic [7:0] OFS_INT_STAT = 8'h1c;
    localparam logic [7:0] OFS_INT_MASK = 8'h20;
    localparam logic [7:0] OFS_SLEEP    = 8'h24;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_FSEL    = 8'h00;
    localparam logic [7:0] RST_PORT    = 8'hff;
    localparam logic [8:0] RST_WAKE_EN = 9'h000;
    localparam logic [7:0] SEL_MASK_A  = 8'h3f;
    localparam logic [7:0] SEL_MASK_B  = 8'hff;
    localparam logic [8:0] WAKE_MASK_A = 9'h1ff;
    localparam logic [8:0] WAKE_MASK_B = 9'h0ff;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BITOP_IDX_LSB = 0;
    localparam int BITOP_VAL_POS = 3;
    localparam int BITOP_TGT_POS = 4;
    localparam int INT_WAKE_POS  = 0;
    localparam int SLEEP_POS     = 0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FN_GPIO, FN_CMP, FN_COM, FN_SEG} pfm_fn_e;

    // cmp[0]/com[0] serve pin 0, cmp[1]/com[1] serve pin 1
    typedef struct packed {
        logic [7:0] seg;
        logic [7:0] segOe;
        logic [1:0] cmp;
        logic [1:0] com;
        logic [1:0] comOe;
    } pfm_periph_s;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pfm_pin_s;

endpackage

// *** core/pfm_top.sv ***
`timescale 1ns/10ps
// How it works
// - variant A pin 2: 11 gives segment 2
// - variant A pins 0,1: comparator or common
// - variant A selector bits 7,6 read zero
// - variant B pins 0-3: 11 gives segments
// - variant B pins 4-7: 11 gives segments
// - reset sets data and direction to ones
// - all pins come out of reset inputs
// - new output drives high after reset
// - direction by byte or by bit
// - bit operation rewrites whole port byte
// - falling edge wakes from sleep
// - wake pins: variant-specific wake port only
// - each wake pin enabled independently
module pfm_top
    import pfm_pkg::*;
#(
    parameter bit IS_B = 1'b0
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic [7:0]  pfIn,
    output pfm_pin_s         pfDrive,
    input  wire pfm_periph_s periph,
    input  wire logic [8:0]  wakeIn,
    output logic             sleepMode,
    output logic             irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    function automatic pfm_fn_e pinFn(input logic isB, input int idx, input logic [1:0] f);
        if (f == 2'b11) begin
            if (isB || idx == 2) begin
                return FN_SEG;
            end
            return (idx < 2) ? FN_COM : FN_GPIO;
        end
        if (f == 2'b10 && !isB && idx < 2) begin
            return FN_CMP;
        end
        return FN_GPIO;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        dpActive_reg;
    logic        dpWrite_reg;
    logic [7:0]  dpAddr_reg;
    logic        hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic [7:0]  fselLo_reg;
    logic [7:0]  fselHi_reg;
    logic [7:0]  data_reg;
    logic [7:0]  dir_reg;
    logic [8:0]  wakeEn_reg;
    logic        intStat_reg;
    logic        intMask_reg;
    logic        sleep_reg;
    logic        irq_reg;
    logic [7:0]  pfMeta;
    logic [7:0]  pfSync;
    logic [8:0]  wkMeta;
    logic [8:0]  wkSync;
    logic [8:0]  wkPrev;
    pfm_pin_s    pfDrive_reg;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire         addrTake = hsel && htrans[1] && hready;
    wire         wrEn     = dpActive_reg && dpWrite_reg;
    wire         wrLo     = wrEn && hit(dpAddr_reg, OFS_FSEL_LO);
    wire         wrHi     = wrEn && hit(dpAddr_reg, OFS_FSEL_HI) && IS_B;
    wire         wrData   = wrEn && hit(dpAddr_reg, OFS_DATA);
    wire         wrDir    = wrEn && hit(dpAddr_reg, OFS_DIR);
    wire         wrBitop  = wrEn && hit(dpAddr_reg, OFS_BITOP);
    wire         wrWake   = wrEn && hit(dpAddr_reg, OFS_WAKE_EN);
    wire         wrStat   = wrEn && hit(dpAddr_reg, OFS_INT_STAT);
    wire         wrMask   = wrEn && hit(dpAddr_reg, OFS_INT_MASK);
    wire         wrSleep  = wrEn && hit(dpAddr_reg, OFS_SLEEP);
    wire [7:0]   wd8      = hwdata[7:0];

    wire [31:0] rdMux =
        hit(dpAddr_reg, OFS_FSEL_LO)  ? {24'h000000, fselLo_reg} :
        hit(dpAddr_reg, OFS_FSEL_HI)  ? {24'h000000, fselHi_reg} :
        hit(dpAddr_reg, OFS_DATA)     ? {24'h000000, data_reg} :
        hit(dpAddr_reg, OFS_DIR)      ? {24'h000000, dir_reg} :
        hit(dpAddr_reg, OFS_PIN)      ? {24'h000000, pfSync} :
        hit(dpAddr_reg, OFS_WAKE_EN)  ? {23'h000000, wakeEn_reg} :
        hit(dpAddr_reg, OFS_INT_STAT) ? {31'h00000000, intStat_reg} :
        hit(dpAddr_reg, OFS_INT_MASK) ? {31'h00000000, intMask_reg} :
        hit(dpAddr_reg, OFS_SLEEP)    ? {31'h00000000, sleep_reg} :
                                        32'h00000000;

    // ------------------------------------------------------------
    // register next values
    // ------------------------------------------------------------
    // unimplemented selector bits
    wire [7:0]  selMask  = IS_B ? SEL_MASK_B : SEL_MASK_A;
    wire [8:0]  wakeMask = IS_B ? WAKE_MASK_B : WAKE_MASK_A;
    wire [7:0]  fselLo_next = wrLo ? (wd8 & selMask) : fselLo_reg;
    wire [7:0]  fselHi_next = wrHi ? wd8 : fselHi_reg;

    // read whole byte, change one bit
    wire [2:0]  bIdx    = hwdata[BITOP_IDX_LSB +: 3];
    wire        bVal    = hwdata[BITOP_VAL_POS];
    wire        bTgtDir = hwdata[BITOP_TGT_POS];
    wire [7:0]  bMask   = 8'h01 << bIdx;
    wire [7:0]  rmwSrc  = bTgtDir ? dir_reg : pfSync;
    wire [7:0]  rmwVal  = (rmwSrc & ~bMask) | (bVal ? bMask : 8'h00);

    wire [7:0]  dir_next  = wrDir ? wd8 : ((wrBitop && bTgtDir) ? rmwVal : dir_reg);
    wire [7:0]  data_next = wrData ? wd8 : ((wrBitop && !bTgtDir) ? rmwVal : data_reg);

    wire [8:0]  wakeEn_next = wrWake ? (hwdata[8:0] & wakeMask) : wakeEn_reg;

    wire [8:0]  wkFall  = wkPrev & ~wkSync & wakeEn_reg;
    wire        wakeEvt = sleep_reg && (|wkFall);
    wire        sleep_next = wakeEvt ? 1'b0 : (wrSleep ? hwdata[SLEEP_POS] : sleep_reg);

    // set beats a same-cycle clear
    wire        intStat_next = (intStat_reg && !(wrStat && hwdata[INT_WAKE_POS])) || wakeEvt;
    wire        intMask_next = wrMask ? hwdata[INT_WAKE_POS] : intMask_reg;

    // ------------------------------------------------------------
    // pin function mux
    // ------------------------------------------------------------
    wire [15:0] sel16 = {fselHi_reg, fselLo_reg};
    pfm_fn_e    fn [8];
    pfm_pin_s   drv_next;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            assign fn[i] = pinFn(IS_B, i, sel16[2*i +: 2]);
            assign drv_next.out[i] =
                (fn[i] == FN_SEG) ? periph.seg[i] :
                (fn[i] == FN_CMP) ? periph.cmp[i % 2] :
                (fn[i] == FN_COM) ? periph.com[i % 2] : data_reg[i];
            assign drv_next.oe[i] =
                (fn[i] == FN_SEG) ? periph.segOe[i] :
                (fn[i] == FN_CMP) ? 1'b1 :
                (fn[i] == FN_COM) ? periph.comOe[i % 2] : !dir_reg[i];
        end
    endgenerate

    // ------------------------------------------------------------
    // flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dpActive_reg  <= 1'b0;
            dpWrite_reg   <= 1'b0;
            dpAddr_reg    <= 8'h00;
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= 32'h00000000;
        end else if (dpActive_reg) begin
            dpActive_reg  <= 1'b0;
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= dpWrite_reg ? 32'h00000000 : rdMux;
        end else if (addrTake) begin
            dpActive_reg  <= 1'b1;
            dpWrite_reg   <= hwrite;
            dpAddr_reg    <= haddr[7:0];
            hreadyout_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fselLo_reg  <= RST_FSEL;
            fselHi_reg  <= RST_FSEL;
            data_reg    <= RST_PORT;
            dir_reg     <= RST_PORT;
            wakeEn_reg  <= RST_WAKE_EN;
            intStat_reg <= 1'b0;
            intMask_reg <= 1'b0;
            sleep_reg   <= 1'b0;
            irq_reg     <= 1'b0;
        end else begin
            fselLo_reg  <= fselLo_next;
            fselHi_reg  <= fselHi_next;
            data_reg    <= data_next;
            dir_reg     <= dir_next;
            wakeEn_reg  <= wakeEn_next;
            intStat_reg <= intStat_next;
            intMask_reg <= intMask_next;
            sleep_reg   <= sleep_next;
            irq_reg     <= intStat_next && intMask_next;
        end
    end

    // pins are asynchronous to sys_clk
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pfMeta      <= RST_PORT;
            pfSync      <= RST_PORT;
            wkMeta      <= 9'h1ff;
            wkSync      <= 9'h1ff;
            wkPrev      <= 9'h1ff;
            pfDrive_reg <= {RST_PORT, 8'h00};
        end else begin
            pfMeta      <= pfIn;
            pfSync      <= pfMeta;
            wkMeta      <= wakeIn;
            wkSync      <= wkMeta;
            wkPrev      <= wkSync;
            pfDrive_reg <= drv_next;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hrdata    = hrdata_reg;
    assign hresp     = 1'b0;
    assign pfDrive   = pfDrive_reg;
    assign sleepMode = sleep_reg;
    assign irq       = irq_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence sqBitopDir;
        dpActive_reg && dpWrite_reg && hit(dpAddr_reg, OFS_BITOP) && hwdata[BITOP_TGT_POS];
    endsequence

    sequence sqWakeWr;
        dpActive_reg && dpWrite_reg && hit(dpAddr_reg, OFS_WAKE_EN);
    endsequence

    sequence sqSleepFall;
        sleep_reg && (|(wkPrev & ~wkSync & wakeEn_reg));
    endsequence

    chk_upper_sel_zero: assert property (!IS_B |-> fselLo_reg[7:6] == 2'b00 && fselHi_reg == 8'h00)
        else $error("variant A unimplemented selector bits set");

    chk_reset_ports: assert property ($past(!rst_n) |-> data_reg == RST_PORT && dir_reg == RST_PORT)
        else $error("port registers not all ones after reset");

    chk_reset_select: assert property ($past(!rst_n) |-> fselLo_reg == RST_FSEL && fselHi_reg == RST_FSEL)
        else $error("selector not zero after reset");

    chk_reset_inputs: assert property ($past(!rst_n) ##1 1'b1 |-> pfDrive_reg.oe == 8'h00)
        else $error("pin driven right after reset");

    chk_bitop_rmw: assert property (sqBitopDir |=>
        ((dir_reg ^ $past(dir_reg)) & ~(8'h01 << $past(hwdata[2:0]))) == 8'h00 &&
        dir_reg[$past(hwdata[2:0])] == $past(hwdata[BITOP_VAL_POS]))
        else $error("bit operation disturbed other direction bits");

    chk_wake_enable: assert property (sqWakeWr |=> wakeEn_reg == ($past(hwdata[8:0]) & wakeMask))
        else $error("wake enable write not stored");

    chk_wake_scope: assert property (IS_B |-> !wakeEn_reg[8])
        else $error("variant B has wake on non-wake pin");

    chk_wake_event: assert property (sqSleepFall |=> !sleep_reg && intStat_reg ##1 irq_reg == intMask_reg)
        else $error("falling edge did not wake");

    chk_bus_wait: assert property (addrTake && !dpActive_reg |=> !hreadyout_reg ##1 hreadyout_reg)
        else $error("bus answer timing wrong");

    generate
        for (i = 0; i < 8; i++) begin : g_chk
            chk_gpio_path: assert property (fn[i] == FN_GPIO |=>
                pfDrive_reg.out[i] == $past(data_reg[i]) && pfDrive_reg.oe[i] == !$past(dir_reg[i]))
                else $error("gpio path wrong");
            chk_seg_path: assert property (fn[i] == FN_SEG |=>
                pfDrive_reg.out[i] == $past(periph.seg[i]) && pfDrive_reg.oe[i] == $past(periph.segOe[i]))
                else $error("segment path wrong");
            chk_seg_field: assert property (sel16[2*i +: 2] == 2'b11 && (IS_B || i == 2) |-> fn[i] == FN_SEG)
                else $error("segment select not decoded");
            chk_cmp_field: assert property (!IS_B && i < 2 && sel16[2*i +: 2] == 2'b10 |=>
                pfDrive_reg.oe[i] && pfDrive_reg.out[i] == $past(periph.cmp[i % 2]))
                else $error("comparator path wrong");
        end
    endgenerate

endmodule

// *** testbench/pfm_board_model.sv ***
`timescale 1ns/10ps
module pfm_board_model
    import pfm_pkg::*;
(
    input  wire pfm_pin_s   drive,
    input  wire logic [7:0] keyLow,
    output logic [7:0]      level
);
    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    // released pins sit at the pull-high
    // a pressed key on a released pin pulls it low
    assign level = (drive.oe & drive.out) | (~drive.oe & ~keyLow);
endmodule

// *** testbench/pfm_top_tb.sv ***
`timescale 1ns/10ps
module pfm_top_tb
    import pfm_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and wiring
    // ------------------------------------------------------------
    localparam pfm_periph_s PV = '{seg: 8'h5a, segOe: 8'h3c, cmp: 2'b10, com: 2'b01, comOe: 2'b10};
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic        selB    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] rdData;
    logic [1:0]  htrans  = 2'b00;
    logic [7:0]  keyLow  = 8'h00;
    logic [8:0]  wakeIn  = 9'h1ff;
    pfm_periph_s periph  = PV;
    logic [15:0] tbl [6] = '{16'h0000, 16'h5555, 16'haaaa, 16'hffff, 16'he41b, 16'h1be4};
    logic        rdyA, rdyB, slpA, slpB, irqA, irqB;
    logic        respA, respB;
    logic [31:0] rdA, rdB;
    logic [7:0]  lvlA, lvlB;
    pfm_pin_s    drvA, drvB;
    int          n_fail   = 0;
    int          compares = 0;
    int          cycles   = 0;
    wire         hselA  = hsel & ~selB;
    wire         hselB  = hsel & selB;
    wire         hready = selB ? rdyB : rdyA;
    wire  [31:0] hrdata = selB ? rdB : rdA;
    wire         slp    = selB ? slpB : slpA;
    wire         irq    = selB ? irqB : irqA;
    wire  [15:0] drv    = selB ? drvB : drvA;

    pfm_top #(.IS_B(1'b0)) u_pfm_top (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hselA), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(rdyA),
        .hrdata(rdA), .hresp(respA), .pfIn(lvlA), .pfDrive(drvA), .periph(periph), .wakeIn(wakeIn),
        .sleepMode(slpA), .irq(irqA)
    );
    pfm_top #(.IS_B(1'b1)) u_pfm_top_b (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hselB), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(rdyB),
        .hrdata(rdB), .hresp(respB), .pfIn(lvlB), .pfDrive(drvB), .periph(periph), .wakeIn(wakeIn),
        .sleepMode(slpB), .irq(irqB)
    );
    pfm_board_model u_pfm_board_model (.drive(drvA), .keyLow(keyLow), .level(lvlA));
    pfm_board_model u_pfm_board_model_b (.drive(drvB), .keyLow(keyLow), .level(lvlB));

    always #50 sys_clk = ~sys_clk;

    // the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("counts: compares=%0d mismatches=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // address phase held until hready, then data phase held until hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rdData = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chkVal(rdData, exp);
    endtask

    task automatic fall(input int b);
        @(posedge sys_clk);
        wakeIn[b] <= 1'b0;
        repeat (6) @(posedge sys_clk);
        wakeIn[b] <= 1'b1;
        tick(4);
    endtask

    function automatic pfm_pin_s expPins(input logic isB, input logic [15:0] sel);
        pfm_pin_s   e;
        logic [1:0] f;
        e.out = 8'h00;
        e.oe  = 8'hff;
        for (int i = 0; i < 8; i++) begin
            f = sel[2*i +: 2];
            if (f == 2'b11 && (isB || i == 2)) begin
                e.out[i] = periph.seg[i];
                e.oe[i]  = periph.segOe[i];
            end else if (!isB && i < 2 && f == 2'b10) begin
                e.out[i] = periph.cmp[i];
            end else if (!isB && i < 2 && f == 2'b11) begin
                e.out[i] = periph.com[i];
                e.oe[i]  = periph.comOe[i];
            end
        end
        return e;
    endfunction

    task automatic muxRun(input logic [15:0] s);
        wr(OFS_FSEL_LO, {24'h0, s[7:0]});
        wr(OFS_FSEL_HI, {24'h0, s[15:8]});
        tick(2);
        chkVal({16'h0, drv}, {16'h0, expPins(selB, selB ? s : {8'h00, s[7:0] & SEL_MASK_A})});
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(1);
        for (int v = 0; v < 2; v++) begin
            @(posedge sys_clk);
            selB <= v[0];
            rdChk(OFS_FSEL_LO, 32'h0);
            rdChk(OFS_FSEL_HI, 32'h0);
            rdChk(OFS_DATA, 32'hff);
            rdChk(OFS_DIR, 32'hff);
            rdChk(8'h80, 32'h0);
            chkVal({24'h0, drv[7:0]}, 32'h0);
        end
        $display("test reset done");
        @(posedge sys_clk);
        selB <= 1'b0;
        wr(OFS_FSEL_LO, 32'hff);
        rdChk(OFS_FSEL_LO, 32'h3f);
        wr(OFS_FSEL_HI, 32'hff);
        rdChk(OFS_FSEL_HI, 32'h0);
        wr(OFS_FSEL_LO, 32'h0);
        wr(OFS_DIR, 32'hfe);
        tick(2);
        chkVal({16'h0, drv}, 32'hff01);
        chkVal({31'h0, lvlA[0]}, 32'h1);
        $display("test selector and output default done");
        for (int v = 0; v < 2; v++) begin
            @(posedge sys_clk);
            selB <= v[0];
            wr(OFS_DATA, 32'h0);
            wr(OFS_DIR, 32'h0);
            for (int p = 0; p < 2; p++) begin
                @(posedge sys_clk);
                periph <= p ? ~PV : PV;
                foreach (tbl[k]) muxRun(tbl[k]);
            end
            muxRun(16'h0000);
        end
        $display("test function mux done");
        wr(OFS_DIR, 32'hff);
        wr(OFS_BITOP, 32'h12);
        rdChk(OFS_DIR, 32'hfb);
        wr(OFS_DATA, 32'hff);
        @(posedge sys_clk);
        keyLow <= 8'h30;
        tick(4);
        rdChk(OFS_PIN, 32'hcf);
        wr(OFS_BITOP, 32'h00);
        rdChk(OFS_DATA, 32'hce);
        $display("test bit operations done");
        wr(OFS_WAKE_EN, 32'h1ff);
        rdChk(OFS_WAKE_EN, 32'h0ff);
        wr(OFS_SLEEP, 32'h1);
        fall(8);
        chkVal({31'h0, slp}, 32'h1);
        fall(7);
        chkVal({31'h0, slp}, 32'h0);
        @(posedge sys_clk);
        selB <= 1'b0;
        wr(OFS_WAKE_EN, 32'h100);
        wr(OFS_INT_MASK, 32'h1);
        wr(OFS_SLEEP, 32'h1);
        fall(0);
        chkVal({31'h0, slp}, 32'h1);
        fall(8);
        chkVal({30'h0, slp, irq}, 32'h1);
        rdChk(OFS_INT_STAT, 32'h1);
        wr(OFS_INT_STAT, 32'h1);
        tick(1);
        chkVal({31'h0, irq}, 32'h0);
        wr(OFS_WAKE_EN, 32'h003);
        wr(OFS_INT_MASK, 32'h0);
        wr(OFS_SLEEP, 32'h1);
        fall(1);
        chkVal({30'h0, slp, irq}, 32'h0);
        rdChk(OFS_INT_STAT, 32'h1);
        $display("test wake-up done");
        // mid-run reset after data, direction and wake enables were changed
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(1);
        rdChk(OFS_DATA, 32'hff);
        rdChk(OFS_DIR, 32'hff);
        rdChk(OFS_WAKE_EN, 32'h0);
        rdChk(OFS_INT_STAT, 32'h0);
        chkVal({24'h0, drv[7:0]}, 32'h0);
        chkVal({31'h0, respA | respB}, 32'h0);
        $display("test second reset done");
        stop_test();
    end
endmodule
